// File: bench/testbench.sv
// testbench: self-checking bench for the tx edge shaping core
// assumes tes_pkg and tes_top compiled first; one 40 MHz clock, carrier ticks made here
`timescale 1ns/1ps
module testbench
  import tes_pkg::*;
;
  logic              clk_sys_i;
  logic              rst_i;
  logic              hsel_i;
  logic [ADDR_W-1:0] haddr_i;
  logic [1:0]        htrans_i;
  logic              hwrite_i;
  logic [2:0]        hsize_i;
  logic [31:0]       hwdata_i;
  logic [31:0]       hrdata_o;
  logic              hreadyout_o;
  logic              hresp_o;
  logic              mod_req_i;
  logic              carrier_tick_i;
  logic [7:0]        power_amp_supply_level_i;
  logic [7:0]        amp_o;
  logic              edge_busy_o;
  int                bad_count;
  int                compares;
  int                cycles;
  logic [7:0]        m0;
  logic [7:0]        m1;
  logic [7:0]        r0;
  logic [7:0]        r1;
  logic [7:0]        msk [NREG] = '{8'hff, 8'hff, 8'h77, 8'h9f, 8'hff, 8'hff, 8'h77, 8'h9f, 8'h01};

  tes_top dut (
    .clk_sys_i                (clk_sys_i),
    .rst_i                    (rst_i),
    .hsel_i                   (hsel_i),
    .haddr_i                  (haddr_i),
    .htrans_i                 (htrans_i),
    .hwrite_i                 (hwrite_i),
    .hsize_i                  (hsize_i),
    .hwdata_i                 (hwdata_i),
    .hready_i                 (hreadyout_o),
    .hrdata_o                 (hrdata_o),
    .hreadyout_o              (hreadyout_o),
    .hresp_o                  (hresp_o),
    .mod_req_i                (mod_req_i),
    .carrier_tick_i           (carrier_tick_i),
    .power_amp_supply_level_i (power_amp_supply_level_i),
    .amp_o                    (amp_o),
    .edge_busy_o              (edge_busy_o)
  );

  // ************************************************************
  // clock, timeout, report
  // ************************************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // ************************************************************
  // ahb-lite master, single word transfers
  // ************************************************************
  task automatic ahb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_sys_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i  <= {idx, 2'h0};
    hwrite_i <= wr;
    hsize_i  <= HSIZE_WORD;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    check({31'h0, hresp_o}, 32'h0, "bus response");
  endtask : ahb

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    logic [31:0] dummy;
    ahb(1'b1, idx, {24'h0, d}, dummy);
  endtask : wr

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, idx, 32'h0, v);
    check(v, exp, "register read");
  endtask : rd

  // ************************************************************
  // edge runner: request, mid sample, tick until idle
  // ************************************************************
  task automatic run_edge(input logic req, input int n_exp, input logic [7:0] fin,
                          output logic [7:0] mid);
    int t;
    t = 0;
    @(posedge clk_sys_i);
    mod_req_i <= req;
    repeat (4) @(posedge clk_sys_i);
    #1;
    mid = amp_o;
    while (edge_busy_o === 1'b1 && t < 80) begin
      @(posedge clk_sys_i);
      carrier_tick_i <= 1'b1;
      @(posedge clk_sys_i);
      carrier_tick_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #1;
      t++;
    end
    check(32'(t), 32'(n_exp), "ticks per edge");
    repeat (2) @(posedge clk_sys_i);
    #1;
    check({24'h0, amp_o}, {24'h0, fin}, "settled amplitude");
  endtask : run_edge

  // mode3 pair of edges with four states
  task automatic pair(input logic [7:0] ty, input logic [7:0] st, output logic [7:0] mf,
                      output logic [7:0] mr);
    wr(IDX_M3_TYPE, ty);
    wr(IDX_M3_STYLE, st);
    run_edge(1'b1, 4, 8'h20, mf);
    run_edge(1'b0, 4, 8'hff, mr);
  endtask : pair

  function automatic logic [31:0] between(input logic [7:0] v, input logic [7:0] lo);
    return {31'h0, (v > lo) && (v < 8'hff)};
  endfunction : between

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst_i = 1'b1;
    hsel_i = 1'b0;
    haddr_i = '0;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hsize_i = HSIZE_WORD;
    hwdata_i = 32'h0;
    mod_req_i = 1'b0;
    carrier_tick_i = 1'b0;
    power_amp_supply_level_i = 8'hff;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    for (int i = 0; i < NREG; i++) begin
      rd(REG_IDX[i], 32'h0);
      wr(REG_IDX[i], 8'hff);
      rd(REG_IDX[i], {24'h0, msk[i]});
      wr(REG_IDX[i], 8'h00);
    end
    wr(9'h060, 8'hff);
    rd(9'h060, 32'h0);
    $display("test registers done");
    wr(IDX_M3_RES, 8'h20);
    wr(IDX_BP_RES, 8'h40);
    wr(IDX_M3_LEN, 8'h04);
    pair(8'h11, 8'h00, m0, m1);
    wr(IDX_M3_LEN, 8'h84);
    run_edge(1'b1, 8, 8'h20, m0);
    run_edge(1'b0, 8, 8'hff, m0);
    wr(IDX_M3_LEN, 8'h00);
    run_edge(1'b1, 0, 8'h20, m0);
    run_edge(1'b0, 0, 8'hff, m0);
    wr(IDX_M3_LEN, 8'h04);
    run_edge(1'b1, 4, 8'h20, m0);
    run_edge(1'b0, 4, 8'hff, m0);
    $display("test lengths done");
    for (int c = 1; c <= 6; c++) begin
      pair({c[3:0], c[3:0]}, 8'h00, m0, m1);
      check(between(m0, 8'h20), 32'h1, "falling mid level");
      check(between(m1, 8'h20), 32'h1, "rising mid level");
    end
    $display("test styles done");
    pair(8'h21, 8'h00, m0, r0);
    pair(8'h21, 8'h70, m1, r1);
    check({31'h0, m0 != m1}, 32'h1, "time constant falling");
    pair(8'h12, 8'h00, m0, r0);
    pair(8'h12, 8'h07, m1, r1);
    check({31'h0, r0 != r1}, 32'h1, "time constant rising");
    pair(8'h44, 8'h00, m0, r0);
    pair(8'h44, 8'h11, m1, r1);
    check({31'h0, m0 != m1}, 32'h1, "table pick falling");
    check({31'h0, r0 != r1}, 32'h1, "table pick rising");
    pair(8'h44, 8'h22, m1, r1);
    check({31'h0, m0 != m1}, 32'h1, "table two falling");
    pair(8'h44, 8'h33, r1, r0);
    check({31'h0, r1 != m0 && r1 != m1}, 32'h1, "table three falling");
    // lower supply: code 4 must not move, codes 5 and 6 must
    @(posedge clk_sys_i);
    power_amp_supply_level_i <= 8'h7f;
    pair(8'h44, 8'h00, r1, r0);
    check({24'h0, r1}, {24'h0, m0}, "table no adaptation");
    pair(8'h55, 8'h00, m1, r0);
    pair(8'h66, 8'h00, r1, r0);
    check({31'h0, m1 != r1}, 32'h1, "supply correction");
    check({31'h0, r1 != m0}, 32'h1, "supply adaptation");
    @(posedge clk_sys_i);
    power_amp_supply_level_i <= 8'hff;
    // zero residual, linear table: rising level is the bare progress, falling level is full minus it
    wr(IDX_M3_RES, 8'h00);
    wr(IDX_M3_TYPE, 8'h44);
    wr(IDX_M3_STYLE, 8'h00);
    run_edge(1'b1, 4, 8'h00, m0);
    check({24'h0, m0}, 32'h0000_00c0, "table zero falling");
    run_edge(1'b0, 4, 8'hff, r0);
    check({24'h0, r0}, 32'h0000_003f, "table zero rising");
    wr(IDX_M3_RES, 8'h20);
    $display("test configs done");
    pair(8'h10, 8'h00, m0, r0);
    check(between(m0, 8'h20), 32'h1, "falling shaped");
    check({24'h0, r0}, 32'h0000_00ff, "rising abrupt");
    pair(8'h01, 8'h00, m0, r0);
    check({24'h0, m0}, 32'h0000_0020, "falling abrupt");
    check(between(r0, 8'h20), 32'h1, "rising shaped");
    $display("test independence done");
    wr(IDX_BP_TYPE, 8'h11);
    wr(IDX_BP_LEN, 8'h02);
    wr(IDX_CTRL, 8'h01);
    run_edge(1'b1, 2, 8'h40, m0);
    rd(IDX_STATUS, 32'h0040_0002);
    run_edge(1'b0, 2, 8'hff, m0);
    wr(IDX_CTRL, 8'h00);
    run_edge(1'b1, 4, 8'h20, m0);
    $display("test bprime done");
    test_done();
  end

endmodule : testbench

// File: rtl/tes_edge_profile.sv
// tes_edge_profile: amplitude of one transition state of an edge
// assumes step below count; table fraction supplied from outside
`timescale 1ns/1ps
module tes_edge_profile
  import tes_pkg::*;
(
  // edge selection
  input  wire logic       falling_i,
  input  wire logic [3:0] style_i,
  input  wire logic [2:0] cfg_i,
  input  wire logic [4:0] step_i,
  input  wire logic [4:0] count_i,
  // levels
  input  wire logic [7:0] residual_i,
  input  wire logic [7:0] supply_i,
  input  wire logic [7:0] lut_frac_i,
  // result
  output logic [7:0]      lin_o,
  output logic [7:0]      amp_o
);

  logic [12:0] num;
  logic [15:0] prod;
  logic [11:0] bend;
  logic [8:0]  fsum;
  logic [7:0]  frac;
  logic [7:0]  delta;
  logic [15:0] span_raw;
  logic [15:0] sc_raw;
  logic [8:0]  span;

  always_comb begin
    num   = 13'((13'(step_i) + 13'h001) * 13'h0ff);
    lin_o = (count_i == 5'h00) ? AMP_FULL : 8'(num / 13'(count_i));
    prod  = 16'(lin_o) * 16'(AMP_FULL - lin_o);
    // bend grows with style code and time constant
    bend  = 12'((12'(style_i - 4'h1) * 12'(cfg_i) * 12'(prod[15:8])) >> 3);
    fsum  = 9'(lin_o) + 9'(bend);
    case (style_i)
      STY_LIN1: frac = lin_o;
      STY_LIN2, STY_LIN3: frac = fsum[8] ? AMP_FULL : fsum[7:0];
      STY_LUT, STY_LUT_CORR, STY_LUT_RAW: frac = lut_frac_i;
      default: frac = AMP_FULL;
    endcase
    delta    = AMP_FULL - residual_i;
    span_raw = 16'(delta) * (16'(frac) + 16'h0001);
    sc_raw   = 16'(span_raw[15:8]) * (16'(supply_i) + 16'h0001);
    case (style_i)
      STY_LUT_CORR: span = 9'(sc_raw[15:8]) + 9'((AMP_FULL - supply_i) >> CORR_SHIFT);
      STY_LUT_RAW:  span = 9'(sc_raw[15:8]);
      default:      span = 9'(span_raw[15:8]);
    endcase
    if (span > 9'(delta)) begin
      span = 9'(delta);
    end
    amp_o = falling_i ? AMP_FULL - span[7:0] : residual_i + span[7:0];
  end

endmodule : tes_edge_profile

// File: rtl/tes_pkg.sv
// tes_pkg: constants and types of the tx edge shaping block
// assumes AHB-Lite word access, byte address = register index * 4
package tes_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int              IDX_W  = 9;
  localparam int              ADDR_W = IDX_W + 2;
  localparam int              NREG   = 9;
  localparam logic [IDX_W-1:0] IDX_M3_RES    = 9'h05c;
  localparam logic [IDX_W-1:0] IDX_M3_TYPE   = 9'h05d;
  localparam logic [IDX_W-1:0] IDX_M3_STYLE  = 9'h05e;
  localparam logic [IDX_W-1:0] IDX_M3_LEN    = 9'h05f;
  localparam logic [IDX_W-1:0] IDX_BP_RES    = 9'h064;
  localparam logic [IDX_W-1:0] IDX_BP_TYPE   = 9'h065;
  localparam logic [IDX_W-1:0] IDX_BP_STYLE  = 9'h066;
  localparam logic [IDX_W-1:0] IDX_BP_LEN    = 9'h067;
  localparam logic [IDX_W-1:0] IDX_CTRL      = 9'h070;
  localparam logic [IDX_W-1:0] IDX_STATUS    = 9'h071;

  // slots of the register array, one mode set of four each, then the control slot
  localparam int MODE3_LONG_RESIDUAL_AMPLITUDE = 0;
  localparam int MODE3_LONG_EDGE_STYLE_SELECT  = 1;
  localparam int MODE3_LONG_EDGE_STYLE_CFG     = 2;
  localparam int MODE3_LONG_EDGE_LENGTH_CFG    = 3;
  localparam int BPRIME_RESIDUAL_AMPLITUDE     = 4;
  localparam int BPRIME_EDGE_TYPE_CFG          = 5;
  localparam int BPRIME_EDGE_STYLE_CFG         = 6;
  localparam int BPRIME_EDGE_LENGTH_CFG        = 7;
  localparam int TX_SHAPE_CTRL                 = 8;

  localparam logic [7:0] MASK_FULL  = 8'hff;
  localparam logic [7:0] MASK_STYLE = 8'h77;
  localparam logic [7:0] MASK_LEN   = 8'h9f;
  localparam logic [7:0] MASK_CTRL  = 8'h01;
  localparam logic [7:0] RST_REG    = 8'h00;

  localparam logic [IDX_W-1:0] REG_IDX [NREG] = '{IDX_M3_RES, IDX_M3_TYPE,
    IDX_M3_STYLE, IDX_M3_LEN, IDX_BP_RES, IDX_BP_TYPE, IDX_BP_STYLE,
    IDX_BP_LEN, IDX_CTRL};
  localparam logic [7:0] REG_MASK [NREG] = '{MASK_FULL, MASK_FULL,
    MASK_STYLE, MASK_LEN, MASK_FULL, MASK_FULL, MASK_STYLE, MASK_LEN,
    MASK_CTRL};

  // ************************************************************
  // fields
  // ************************************************************
  localparam int FALL_LSB   = 4;
  localparam int RISE_LSB   = 0;
  localparam int LEN_DBL    = 7;
  localparam int LEN_CNT_LSB = 0;
  localparam int CTRL_BP    = 0;

  // ************************************************************
  // style codes and levels
  // ************************************************************
  localparam logic [3:0] STY_LIN1     = 4'h1;
  localparam logic [3:0] STY_LIN2     = 4'h2;
  localparam logic [3:0] STY_LIN3     = 4'h3;
  localparam logic [3:0] STY_LUT      = 4'h4;
  localparam logic [3:0] STY_LUT_CORR = 4'h5;
  localparam logic [3:0] STY_LUT_RAW  = 4'h6;
  localparam logic [7:0] AMP_FULL     = 8'hff;
  localparam int         CORR_SHIFT   = 3;
  localparam logic [2:0] HSIZE_WORD   = 3'h2;

  typedef enum logic [1:0] {ST_HIGH, ST_FALL, ST_LOW, ST_RISE} tes_state_t;

endpackage : tes_pkg

// File: rtl/tes_table_curve.sv
// tes_table_curve: four fixed shaping tables, progress in, fraction out
// assumes progress 0..ff from the edge profile
`timescale 1ns/1ps
module tes_table_curve
  import tes_pkg::*;
(
  // table pick and progress
  input  wire logic [1:0] table_i,
  input  wire logic [7:0] lin_i,
  // shaped fraction
  output logic [7:0]      frac_o
);

  function automatic logic [7:0] sq_shr(input logic [7:0] x, input int sh);
    logic [15:0] p;
    p = 16'(x) * 16'(x);
    return 8'(p >> sh);
  endfunction : sq_shr

  // ************************************************************
  // table contents
  // ************************************************************
  always_comb begin
    case (table_i)
      2'h0:    frac_o = lin_i;
      2'h1:    frac_o = sq_shr(lin_i, 8);
      2'h2:    frac_o = AMP_FULL - sq_shr(AMP_FULL - lin_i, 8);
      default: begin
        if (lin_i[7] == 1'b0) begin
          frac_o = sq_shr(lin_i, 7);
        end else begin
          frac_o = AMP_FULL - sq_shr(AMP_FULL - lin_i, 7);
        end
      end
    endcase
  end

endmodule : tes_table_curve

// File: rtl/tes_top.sv
// tes_top: tx edge shaping core with an AHB-Lite register slave
// assumes one clock; modulation request, carrier tick and supply
// level come from logic on the same clock
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module tes_top
  import tes_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // ahb-lite slave
  input  wire logic              hsel_i,
  input  wire logic [ADDR_W-1:0] haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic [31:0]            hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  // transmitter side
  input  wire logic              mod_req_i,
  input  wire logic              carrier_tick_i,
  input  wire logic [7:0]        power_amp_supply_level_i,
  output logic [7:0]             amp_o,
  output logic                   edge_busy_o
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic             wr_pend_reg;
  logic [IDX_W-1:0] wr_idx_reg;
  logic             acc_ok;
  logic [7:0]       cfg_reg  [NREG];
  logic [7:0]       cfg_next [NREG];
  logic [31:0]      hrdata_next;
  tes_state_t       state_reg;
  logic [4:0]       step_reg;
  logic [4:0]       cnt_reg;
  logic             dbl_reg;
  logic             half_reg;
  logic             bp_mode;
  logic [7:0]       res_sel;
  logic [7:0]       type_sel;
  logic [7:0]       style_sel;
  logic [7:0]       len_sel;
  logic             in_edge;
  logic             falling;
  logic [3:0]       act_style;
  logic [2:0]       act_cfg;
  logic [7:0]       lin;
  logic [7:0]       lut_frac;
  logic [7:0]       prof_amp;
  logic             step_done;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  function automatic logic [IDX_W-1:0] word_idx(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction : word_idx

  function automatic int mode_slot(input logic bp, input int k);
    return bp ? BPRIME_RESIDUAL_AMPLITUDE + k : MODE3_LONG_RESIDUAL_AMPLITUDE + k;
  endfunction : mode_slot

  // ************************************************************
  // bus address phase
  // ************************************************************
  assign acc_ok = hsel_i && htrans_i[1] && hready_i && (hsize_i == HSIZE_WORD);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= '0;
    end else begin
      wr_pend_reg <= acc_ok && hwrite_i;
      wr_idx_reg  <= word_idx(haddr_i);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // ************************************************************
  // register file
  // ************************************************************
  // writes land in the data phase; reserved bits are dropped
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      cfg_next[i] = cfg_reg[i];
      if (wr_pend_reg && (wr_idx_reg == REG_IDX[i])) begin
        cfg_next[i] = hwdata_i[7:0] & REG_MASK[i];
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NREG; i++) begin
        cfg_reg[i] <= RST_REG;
      end
    end else begin
      for (int i = 0; i < NREG; i++) begin
        cfg_reg[i] <= cfg_next[i];
      end
    end
  end

  // read uses next values so a write just before is seen
  always_comb begin
    hrdata_next = 32'h0000_0000;
    for (int i = 0; i < NREG; i++) begin
      if (word_idx(haddr_i) == REG_IDX[i]) begin
        hrdata_next = {24'h00_0000, cfg_next[i]};
      end
    end
    if (word_idx(haddr_i) == IDX_STATUS) begin
      hrdata_next = {8'h00, amp_o, 3'h0, step_reg, 4'h0, dbl_reg, half_reg,
                     state_reg};
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (acc_ok && !hwrite_i) begin
      hrdata_o <= hrdata_next;
    end
  end

  // ************************************************************
  // active setting set
  // ************************************************************
  assign bp_mode   = cfg_reg[TX_SHAPE_CTRL][CTRL_BP];
  assign res_sel   = cfg_reg[mode_slot(bp_mode, 0)];
  assign type_sel  = cfg_reg[mode_slot(bp_mode, 1)];
  assign style_sel = cfg_reg[mode_slot(bp_mode, 2)];
  assign len_sel   = cfg_reg[mode_slot(bp_mode, 3)];

  assign in_edge   = (state_reg == ST_FALL) || (state_reg == ST_RISE);
  assign falling   = (state_reg != ST_RISE);
  assign act_style = falling ? type_sel[FALL_LSB+:4] : type_sel[RISE_LSB+:4];
  assign act_cfg   = falling ? style_sel[FALL_LSB+:3] : style_sel[RISE_LSB+:3];
  // a transition state ends on its first or second carrier cycle
  assign step_done = carrier_tick_i && (!dbl_reg || half_reg);

  // ************************************************************
  // edge sequencer
  // ************************************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_HIGH;
      step_reg  <= 5'h00;
      cnt_reg   <= 5'h00;
      dbl_reg   <= 1'b0;
    end else begin
      case (state_reg)
        ST_HIGH: begin
          if (mod_req_i) begin
            step_reg  <= 5'h00;
            cnt_reg   <= len_sel[LEN_CNT_LSB+:5];
            dbl_reg   <= len_sel[LEN_DBL];
            state_reg <= (len_sel[LEN_CNT_LSB+:5] == 5'h00) ? ST_LOW : ST_FALL;
          end
        end
        ST_LOW: begin
          if (!mod_req_i) begin
            step_reg  <= 5'h00;
            cnt_reg   <= len_sel[LEN_CNT_LSB+:5];
            dbl_reg   <= len_sel[LEN_DBL];
            state_reg <= (len_sel[LEN_CNT_LSB+:5] == 5'h00) ? ST_HIGH : ST_RISE;
          end
        end
        ST_FALL, ST_RISE: begin
          if (step_done) begin
            if (step_reg == cnt_reg - 5'h01) begin
              step_reg  <= 5'h00;
              state_reg <= (state_reg == ST_FALL) ? ST_LOW : ST_HIGH;
            end else begin
              step_reg <= step_reg + 5'h01;
            end
          end
        end
        default: state_reg <= ST_HIGH;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      half_reg <= 1'b0;
    end else if (!in_edge) begin
      half_reg <= 1'b0;
    end else if (carrier_tick_i) begin
      half_reg <= dbl_reg && !half_reg;
    end
  end

  // ************************************************************
  // amplitude shaping
  // ************************************************************
  tes_edge_profile u_profile (
    .falling_i  (falling),
    .style_i    (act_style),
    .cfg_i      (act_cfg),
    .step_i     (step_reg),
    .count_i    (cnt_reg),
    .residual_i (res_sel),
    .supply_i   (power_amp_supply_level_i),
    .lut_frac_i (lut_frac),
    .lin_o      (lin),
    .amp_o      (prof_amp)
  );

  tes_table_curve u_curve (
    .table_i (act_cfg[1:0]),
    .lin_i   (lin),
    .frac_o  (lut_frac)
  );

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      amp_o       <= AMP_FULL;
      edge_busy_o <= 1'b0;
    end else begin
      edge_busy_o <= in_edge;
      case (state_reg)
        ST_HIGH: amp_o <= AMP_FULL;
        ST_LOW:  amp_o <= res_sel;
        default: amp_o <= prof_amp;
      endcase
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  chk_fall_style: assert property (
    (state_reg == ST_FALL) |-> (act_style == type_sel[7:4]))
    else $error("falling edge style not from upper nibble");

  chk_rise_style: assert property (
    (state_reg == ST_RISE) |-> (act_style == type_sel[3:0]))
    else $error("rising edge style not from lower nibble");

  chk_reserved_jump: assert property (
    (in_edge && (act_style == 4'h0 || act_style > 4'h6))
      |-> (prof_amp == (falling ? res_sel : 8'hff)))
    else $error("reserved style did not switch abruptly");

  chk_table_pick: assert property (
    (in_edge && act_style == 4'h4 && act_cfg[1:0] == 2'h0 && res_sel == 8'h00)
      |-> (prof_amp == (falling ? 8'hff - lin : lin)))
    else $error("table zero is not the linear table");

  chk_double_state: assert property (
    (state_reg == ST_FALL && dbl_reg && carrier_tick_i && !half_reg)
      |=> (state_reg == ST_FALL && step_reg == $past(step_reg) && half_reg))
    else $error("doubled state ended after one carrier cycle");

  chk_double_rise: assert property (
    (state_reg == ST_RISE && dbl_reg && carrier_tick_i && !half_reg)
      |=> (state_reg == ST_RISE && step_reg == $past(step_reg) && half_reg))
    else $error("doubled rising state ended after one carrier cycle");

  chk_single_state: assert property (
    (state_reg == ST_FALL && !dbl_reg && carrier_tick_i
      && step_reg < cnt_reg - 5'h01)
      |=> (state_reg == ST_FALL && step_reg == $past(step_reg) + 5'h01))
    else $error("single state did not advance on carrier cycle");

  chk_state_count: assert property (
    (state_reg == ST_FALL && step_done && step_reg == cnt_reg - 5'h01)
      |=> (state_reg == ST_LOW) ##1 (amp_o == $past(res_sel)))
    else $error("falling edge did not end after its state count");

  chk_rise_count: assert property (
    (state_reg == ST_RISE && step_done && step_reg == cnt_reg - 5'h01)
      |=> (state_reg == ST_HIGH) ##1 (amp_o == AMP_FULL))
    else $error("rising edge did not end after its state count");

  chk_zero_count: assert property (
    (state_reg == ST_HIGH && mod_req_i && len_sel[LEN_CNT_LSB+:5] == 5'h00)
      |=> (state_reg == ST_LOW))
    else $error("zero state count did not switch at once");

  chk_bprime_set: assert property (
    bp_mode |-> (res_sel == cfg_reg[BPRIME_RESIDUAL_AMPLITUDE]
      && type_sel == cfg_reg[BPRIME_EDGE_TYPE_CFG]))
    else $error("b-prime mode not using its own settings");

  chk_low_level: assert property (
    (state_reg == ST_LOW) |=> (amp_o == $past(res_sel)))
    else $error("modulated level differs from residual amplitude");

endmodule : tes_top
